// file: src/seq_map.svh
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// instruction flow class codes
`define FLOW_SINGLE      3'h0
`define FLOW_TWO_CYCLE   3'h1
`define FLOW_BRANCH      3'h2
`define FLOW_TABLE       3'h3
`define FLOW_TWO_WORD    3'h4
`define FLOW_LOOP_SETUP  3'h5
`define FLOW_REPEAT      3'h6
// status register field position, repeat counter width and repeat literal width
`define RA_BIT           4
`define CNT_W            16
`define LIT_W            15
// cycle costs
`define COST_TWO_CYCLE   3'h2
`define COST_BRANCH      3'h4
`define COST_TWO_WORD    3'h4
`endif

// file: src/seq_pkg.sv
package seq_pkg;
   typedef enum logic [2:0]
   {
      ST_RUN    = 3'b000,
      ST_BUSY   = 3'b001,
      ST_FLUSH  = 3'b010,
      ST_TABLE  = 3'b011,
      ST_OPER   = 3'b100,
      ST_STALL  = 3'b101
   } flow_state_e;

   // one decoded instruction handed in by the decoder
   typedef struct packed
   {
      logic        valid;
      logic [2:0]  flow;
      logic        rpt_from_reg;
      logic [14:0] rpt_lit;
      logic [15:0] rpt_reg;
      logic        addr_dep;
      logic        second_word;
   } instr_s;
endpackage

// file: src/repeat_counter.sv
`timescale 1ns/1ns
`include "seq_map.svh"
module repeat_counter
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                load,
   input  wire logic [`CNT_W-1:0]   load_val,
   input  wire logic                step,
   input  wire logic                exc_clear,
   output logic      [`CNT_W-1:0]   count,
   output logic                     active
);
   logic [`CNT_W-1:0] count_reg;
   logic [`CNT_W-1:0] count_next;
   logic              active_reg;
   logic              active_next;
   wire               at_last = (count_reg == 16'h0001);

   // load wins over step; count stays at zero once reached
   assign count_next  = load ? load_val :
                        (step && active_reg) ? count_reg - 16'h0001 : count_reg;
   // flag only ever changes by hardware events
   assign active_next = load ? (load_val != 16'h0000) :
                        exc_clear ? 1'b0 :
                        (step && active_reg && at_last) ? 1'b0 : active_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg  <= 16'h0000;
         active_reg <= 1'b0;
      end
      else
      begin
         count_reg  <= count_next;
         active_reg <= active_next;
      end
   end

   assign count  = count_reg;
   assign active = active_reg;

   property p_dec;
      @(posedge clk) disable iff (!arst_n)
      (step && active_reg && !load) |=> (count_reg == $past(count_reg) - 16'h0001);
   endproperty
   a_dec: assert property (p_dec) else $error("repeat count did not decrement");

   property p_zero_clear;
      @(posedge clk) disable iff (!arst_n)
      (count_reg == 16'h0000) |-> !active_reg;
   endproperty
   a_zero_clear: assert property (p_zero_clear) else $error("flag set with zero count");
endmodule

// file: src/fetch_execute_repeat_sequencer.sv
`timescale 1ns/1ns
`include "seq_map.svh"
// Overview of operation
// - single-word instructions retire one per cycle
// - two-cycle ops keep prefetched word
// - flow change flushes prefetch, four cycles
// - table ops replace fetch with memory cycle
// - word fetched during table held one cycle
// - two-word jump and call take four cycles
// - orphan second word executes as no-op
// - loop end equals start plus offset
// - address dependency inserts one stall cycle
// - repeat reruns the following instruction
// - executions equal count plus one
// - repeat loads sixteen-bit repeat count
// - repeat-active set when count non-zero
// - software cannot change repeat-active flag
// - program counter held while repeat-active flag set, except on a branch
// - zero count repeat acts as no-op
// - exception saves flag then clears it; a repeat load in the same cycle wins
module fetch_execute_repeat_sequencer
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire seq_pkg::instr_s      instr,
   input  wire logic [23:0]          branch_target,
   input  wire logic [23:0]          loop_offset,
   input  wire logic                 exc_entry,
   output logic                      fetch_en,
   output logic                      table_cycle,
   output logic                      exec_en,
   output logic                      nop_exec,
   output logic                      flush,
   output logic                      pc_inc,
   output logic [23:0]               pc,
   output logic [23:0]               loop_end,
   output logic [`CNT_W-1:0]         repeat_count_reg,
   output logic                      repeat_active_flag,
   output logic [7:0]                status_low_byte,
   output logic                      status_push
);
   seq_pkg::flow_state_e state_reg;
   seq_pkg::flow_state_e state_next;
   logic [2:0]           wait_reg;
   logic [2:0]           wait_next;
   logic [23:0]          pc_reg;
   logic [23:0]          pc_next;
   logic                 first_word_reg;
   logic [2:0]           flow_reg;
   logic [`CNT_W-1:0]    cnt;
   logic                 act;
   logic                 fetch_reg;
   logic                 tbl_reg;
   logic                 exec_reg;
   logic                 nop_reg;
   logic                 flush_reg;
   logic                 inc_reg;
   logic [23:0]          lend_reg;
   logic [7:0]           srl_reg;
   logic                 push_reg;

   // decode of the incoming flow class, used by several paths
   function automatic logic is_flow(input logic [2:0] f, input logic [2:0] want);
      is_flow = (f == want);
   endfunction

   wire               run       = (state_reg == seq_pkg::ST_RUN);
   wire               take      = run && instr.valid;
   wire               orphan    = take && instr.second_word && !first_word_reg;
   wire               do_rpt    = take && is_flow(instr.flow, `FLOW_REPEAT);
   wire               do_two    = take && is_flow(instr.flow, `FLOW_TWO_CYCLE);
   wire               do_br     = take && is_flow(instr.flow, `FLOW_BRANCH);
   wire               do_tbl    = take && is_flow(instr.flow, `FLOW_TABLE);
   wire               do_2w     = take && !orphan && is_flow(instr.flow, `FLOW_TWO_WORD);
   wire               do_loop   = take && !orphan && is_flow(instr.flow, `FLOW_LOOP_SETUP);
   wire               do_dep    = take && instr.addr_dep;
   // repeat count: literal zero-extended, or full working register
   wire [`CNT_W-1:0]  rpt_val   = instr.rpt_from_reg ? instr.rpt_reg :
                                  {1'b0, instr.rpt_lit};
   // each execution while the loop is active consumes one count
   wire               rpt_step  = take && act && !do_rpt;
   // pc held for every non-branch take that finds the repeat-active flag set; the repeat itself
   // steps onto its target and the last run, with count zero, moves on
   wire               hold_pc   = act;
   wire               exc_clr   = exc_entry;

   repeat_counter u_rc
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .load      (do_rpt),
      .load_val  (rpt_val),
      .step      (rpt_step),
      .exc_clear (exc_clr),
      .count     (cnt),
      .active    (act)
   );

   // next state: extra cycles for the multi-cycle flow classes
   always_comb
   begin
      state_next = state_reg;
      wait_next  = wait_reg;
      unique case (state_reg)
         seq_pkg::ST_RUN:
         begin
            if (do_dep)
            begin
               state_next = seq_pkg::ST_STALL;
               wait_next  = 3'h1;
            end
            else if (do_two || do_loop)
            begin
               state_next = seq_pkg::ST_BUSY;
               wait_next  = `COST_TWO_CYCLE - 3'h1;
            end
            else if (do_br)
            begin
               state_next = seq_pkg::ST_FLUSH;
               wait_next  = `COST_BRANCH - 3'h1;
            end
            else if (do_2w)
            begin
               state_next = seq_pkg::ST_OPER;
               wait_next  = `COST_TWO_WORD - 3'h1;
            end
            else if (do_tbl)
            begin
               state_next = seq_pkg::ST_TABLE;
               wait_next  = 3'h1;
            end
         end
         seq_pkg::ST_BUSY, seq_pkg::ST_FLUSH, seq_pkg::ST_TABLE,
         seq_pkg::ST_OPER, seq_pkg::ST_STALL:
         begin
            wait_next = wait_reg - 3'h1;
            if (wait_reg == 3'h1)
               state_next = seq_pkg::ST_RUN;
         end
         default:
            state_next = seq_pkg::ST_RUN;
      endcase
   end

   // program counter: flow change loads target, repeat inhibits increment
   assign pc_next = do_br ? branch_target :
                    (take && !hold_pc) ? pc_reg + 24'h000002 : pc_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= seq_pkg::ST_RUN;
         wait_reg  <= 3'h0;
         pc_reg    <= 24'h000000;
      end
      else
      begin
         state_reg <= state_next;
         wait_reg  <= wait_next;
         pc_reg    <= pc_next;
      end
   end

   // remember whether the last word taken opened a two-word instruction
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         first_word_reg <= 1'b0;
         flow_reg       <= `FLOW_SINGLE;
      end
      else if (take)
      begin
         first_word_reg <= is_flow(instr.flow, `FLOW_TWO_WORD) ||
                           is_flow(instr.flow, `FLOW_LOOP_SETUP);
         flow_reg       <= instr.flow;
      end
   end

   // registered pipeline controls; all outputs come from flip-flops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fetch_reg <= 1'b1;
         tbl_reg   <= 1'b0;
         exec_reg  <= 1'b0;
         nop_reg   <= 1'b0;
         flush_reg <= 1'b0;
         inc_reg   <= 1'b0;
      end
      else
      begin
         // table cycle replaces the fetch; a repeat stops fetching too
         fetch_reg <= !(state_next == seq_pkg::ST_TABLE) && !hold_pc;
         tbl_reg   <= (state_next == seq_pkg::ST_TABLE);
         exec_reg  <= take;
         nop_reg   <= orphan;
         flush_reg <= do_br;
         inc_reg   <= take && !hold_pc && !do_br;
      end
   end

   // loop end address formed from second word offset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         lend_reg <= 24'h000000;
      else if (do_loop)
         lend_reg <= pc_reg + 24'h000004 + loop_offset;
   end

   // exception entry: stack low status byte holding the pre-clear flag
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         srl_reg  <= 8'h00;
         push_reg <= 1'b0;
      end
      else
      begin
         srl_reg  <= {3'h0, act, 4'h0};
         push_reg <= exc_entry;
      end
   end

   assign fetch_en           = fetch_reg;
   assign table_cycle        = tbl_reg;
   assign exec_en            = exec_reg;
   assign nop_exec           = nop_reg;
   assign flush              = flush_reg;
   assign pc_inc             = inc_reg;
   assign pc                 = pc_reg;
   assign loop_end           = lend_reg;
   assign repeat_count_reg   = cnt;
   assign repeat_active_flag = act;
   assign status_low_byte    = srl_reg;
   assign status_push        = push_reg;

   sequence s_branch_taken;
      do_br;
   endsequence

   property p_branch_cost;
      @(posedge clk) disable iff (!arst_n)
      s_branch_taken |=> !run [*3] ##1 run;
   endproperty
   a_branch_cost: assert property (p_branch_cost) else $error("branch cost wrong");

   property p_two_cycle;
      @(posedge clk) disable iff (!arst_n)
      (do_two && !do_dep) |=> !run ##1 run;
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("two-cycle cost wrong");

   property p_two_word;
      @(posedge clk) disable iff (!arst_n)
      (do_2w && !do_dep) |=> !run [*3] ##1 run;
   endproperty
   a_two_word: assert property (p_two_word) else $error("two-word cost wrong");

   property p_table;
      @(posedge clk) disable iff (!arst_n)
      (do_tbl && !do_dep) |=> table_cycle && !fetch_en ##1 run;
   endproperty
   a_table: assert property (p_table) else $error("table cycle missing");

   property p_stall;
      @(posedge clk) disable iff (!arst_n)
      do_dep |=> (state_reg == seq_pkg::ST_STALL) ##1 run;
   endproperty
   a_stall: assert property (p_stall) else $error("dependency stall wrong");

   property p_orphan;
      @(posedge clk) disable iff (!arst_n)
      orphan |=> nop_exec;
   endproperty
   a_orphan: assert property (p_orphan) else $error("orphan word not a no-op");

   property p_pc_hold;
      @(posedge clk) disable iff (!arst_n)
      (act && !do_br) |=> $stable(pc_reg);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved during repeat");

   property p_rpt_load;
      @(posedge clk) disable iff (!arst_n)
      do_rpt |=> (repeat_count_reg == $past(rpt_val)) &&
                 (repeat_active_flag == ($past(rpt_val) != 16'h0000));
   endproperty
   a_rpt_load: assert property (p_rpt_load) else $error("repeat load wrong");

   property p_exc;
      @(posedge clk) disable iff (!arst_n)
      exc_entry |=> !repeat_active_flag && status_push &&
                    (status_low_byte[`RA_BIT] == $past(act));
   endproperty
   a_exc: assert property (p_exc) else $error("exception flag handling wrong");
endmodule

// file: test/prog_mem_model.sv
`timescale 1ns/1ns
// program memory seen from the sequencer: counts fetch and table cycles it is asked for
module prog_mem_model
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        fetch_en,
   input  wire logic        table_cycle,
   input  wire logic [23:0] pc,
   output int               fetch_count,
   output int               table_count
);
   // a table cycle takes the memory slot in place of a fetch, never both at once
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fetch_count <= 0;
         table_count <= 0;
      end
      else if (table_cycle)
         table_count <= table_count + 1;
      else if (fetch_en && pc[0] == 1'b0)
         fetch_count <= fetch_count + 1;
   end
endmodule

// file: test/fetch_execute_repeat_sequencer_test.sv
`timescale 1ns/1ns
`include "seq_map.svh"
module fetch_execute_repeat_sequencer_test;
   logic            clk;
   logic            arst_n;
   seq_pkg::instr_s instr;
   seq_pkg::instr_s filler;
   logic [23:0]     branch_target;
   logic [23:0]     loop_offset;
   logic            exc_entry;
   logic            fetch_en, table_cycle, exec_en, nop_exec, flush, pc_inc;
   logic [23:0]     pc, loop_end;
   logic [15:0]     repeat_count_reg;
   logic            repeat_active_flag, status_push;
   logic [7:0]      status_low_byte;
   int              mismatches, checks, cycles, fetch_count, table_count;
   seq_pkg::instr_s r;

   fetch_execute_repeat_sequencer dut (.clk(clk), .arst_n(arst_n), .instr(instr),
      .branch_target(branch_target), .loop_offset(loop_offset), .exc_entry(exc_entry),
      .fetch_en(fetch_en), .table_cycle(table_cycle), .exec_en(exec_en), .nop_exec(nop_exec),
      .flush(flush), .pc_inc(pc_inc), .pc(pc), .loop_end(loop_end),
      .repeat_count_reg(repeat_count_reg), .repeat_active_flag(repeat_active_flag),
      .status_low_byte(status_low_byte), .status_push(status_push));

   prog_mem_model mem (.clk(clk), .arst_n(arst_n), .fetch_en(fetch_en),
      .table_cycle(table_cycle), .pc(pc), .fetch_count(fetch_count),
      .table_count(table_count));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // cut a hang short; the whole run needs far fewer cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   // expected cycles from one take to the next one
   function automatic int cost_of(input seq_pkg::instr_s i);
      if (i.addr_dep)
         return 2;
      case (i.flow)
         `FLOW_TWO_CYCLE, `FLOW_TABLE, `FLOW_LOOP_SETUP: return 2;
         `FLOW_BRANCH, `FLOW_TWO_WORD:                  return 4;
         default:                                       return 1;
      endcase
   endfunction

   // offer one instruction, keep singles queued behind it, measure the gap
   task automatic run(input seq_pkg::instr_s i);
      logic [23:0] p;
      logic [31:0] t;
      int          n;
      t = $urandom();
      @(posedge clk);
      instr         <= i;
      branch_target <= {t[23:1], 1'b0};
      loop_offset   <= {8'h00, t[31:16]};
      #1 p = pc;
      @(posedge clk);
      instr <= filler;
      #1;
      chk(exec_en === 1'b1, "instruction not retired");
      if (i.flow == `FLOW_BRANCH)
         chk(flush === 1'b1 && pc === branch_target, "flow change");
      else if (i.flow != `FLOW_TWO_WORD && i.flow != `FLOW_LOOP_SETUP)
         chk(flush === 1'b0 && pc === p + 24'h2, "prefetch kept");
      if (i.flow == `FLOW_TABLE)
         chk(table_cycle === 1'b1 && fetch_en === 1'b0, "table slot");
      if (i.flow == `FLOW_LOOP_SETUP)
         chk(loop_end === p + 24'h4 + loop_offset, "loop end");
      if (i.second_word)
         chk(nop_exec === 1'b1, "orphan word");
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (exec_en !== 1'b1 && n < 10);
      chk(n == cost_of(i), "cycle cost");
   endtask

   // repeat with count v, then follow lim executions of the target
   task automatic rpt(input logic from_reg, input logic [15:0] v, input int lim);
      seq_pkg::instr_s i;
      int              n;
      i              = filler;
      i.flow         = `FLOW_REPEAT;
      i.rpt_from_reg = from_reg;
      i.rpt_reg      = v;
      i.rpt_lit      = v[14:0];
      n              = from_reg ? int'(v) : int'(v[14:0]);
      @(posedge clk);
      instr <= i;
      @(posedge clk);
      instr <= filler;
      #1;
      chk(repeat_count_reg === n[15:0], "count load");
      chk(repeat_active_flag === (n != 0), "flag load");
      chk(pc_inc === 1'b1 && fetch_en === 1'b1, "repeat did not move on");
      for (int k = 1; k <= lim; k++)
      begin
         @(posedge clk);
         #1;
         chk(exec_en === 1'b1, "target not run");
         chk(repeat_count_reg === ((k <= n) ? 16'(n - k) : 16'h0000), "count step");
         chk(repeat_active_flag === (k < n), "flag step");
         if (k <= n)
            chk(pc_inc === 1'b0 && fetch_en === 1'b0, "pc moved");
         else
            chk(pc_inc === 1'b1, "pc not resumed");
         if (n == 0)
            chk(pc_inc === 1'b1, "zero count held pc");
      end
   endtask

   initial
   begin
      arst_n        = 1'b0;
      instr         = '0;
      branch_target = 24'h000000;
      loop_offset   = 24'h000000;
      exc_entry     = 1'b0;
      filler        = '0;
      filler.valid  = 1'b1;
      void'($urandom(32'hd3bd7399));
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      // every flow class except repeat once, then an address stall and an orphan word
      for (int f = 0; f < 6; f++)
      begin
         r      = filler;
         r.flow = f[2:0];
         run(r);
      end
      r          = filler;
      r.addr_dep = 1'b1;
      run(r);
      r             = filler;
      r.second_word = 1'b1;
      run(r);
      // random mix, each op separated from the next by filler singles
      for (int j = 0; j < 40; j++)
      begin
         r          = filler;
         r.flow     = 3'($urandom_range(0, 5));
         r.addr_dep = (r.flow == `FLOW_SINGLE) ? 1'($urandom_range(0, 1)) : 1'b0;
         r.rpt_reg  = 16'($urandom());
         run(r);
      end
      // repeat counts at the edges and at random
      rpt(1'b0, 16'h0000, 2);
      rpt(1'b0, 16'h0001, 3);
      rpt(1'b0, 16'h0002, 4);
      rpt(1'b1, 16'h0005, 7);
      for (int j = 0; j < 4; j++)
         rpt(1'($urandom_range(0, 1)), 16'($urandom_range(0, 7)), 9);
      // large count, broken off by an exception
      rpt(1'b1, 16'h8001, 3);
      @(posedge clk);
      exc_entry <= 1'b1;
      @(posedge clk);
      exc_entry <= 1'b0;
      #1 chk(status_push === 1'b1 && status_low_byte === 8'h10, "flag not saved");
      @(posedge clk);
      #1 chk(repeat_active_flag === 1'b0, "flag not cleared");
      chk(table_count != 0, "no table cycle seen");
      // second reset in mid-run, then ordinary flow again
      @(posedge clk);
      instr  <= '0;
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      run(filler);
      chk(fetch_count != 0, "no fetch after reset");
      wrap_up();
   end
endmodule
